//--- src/memory_channel_perf_counters.v
// Channel counter set: four event counters, a clock counter, registers.
//
// What this block does
// - Every counter, general and fixed, holds a 48-bit count.
// - A carry out of count bit 47 flags an overflow.
// - After overflow the counter wraps and keeps counting until globally stopped.
// - Software may preload any count, so overflow follows N events later.
// - Counters read back live while they keep counting.
// - The fixed counter adds one on every DRAM clock cycle.
// - The fixed counter runs on the steady DRAM clock, not the uncore clock.
// - Fixed overflow with notify enabled sends an overflow message outward.
// - Writing one to fixed control bit 19 zeroes the fixed counter.
// - Counter registers are 64 bits: 47:0 read/write, 63:48 ignored, reset zero.
// - Codes 0x01, 0x02, 0x04 count activates, precharges, column commands.
// - Codes 0x05 and 0x06 count refreshes and precharge-all commands.
// - Code 0x07 counts cycles in read or write major mode.
// - Codes 0x10, 0x11 count read queue allocations and not-empty cycles.
// - Codes 0x20, 0x21, 0x22 count write queue allocations, not-empty, full.
// - Codes 0xb0 to 0xb7 count read column accesses per rank 0 to 7.
// - Codes 0xb8 to 0xbf count write column accesses per rank 0 to 7.
// - Codes 0xc0, 0xc1 count low-threshold mode switches and wrong-mode cycles.
// - Counters take multi-count increments; buffer occupancy adds up to 63.
// - General control holds event code in 7:0 and sub-event mask in 15:8.
// - General overflow with notify enabled sets status and sends a message.
//
// Decided for this implementation: strobed register access and the address map.
`default_nettype none
`include "perf_counters_defs.vh"

module memory_channel_perf_counters (
    // Clock and reset
    input  wire                  i_clk,
    input  wire                  i_sys_rst,
    // Register port
    input  wire [`ADDR_W-1:0]    i_addr,
    input  wire [`DATA_W-1:0]    i_wr_data,
    input  wire                  i_wr_stb,
    input  wire                  i_rd_stb,
    output wire [`DATA_W-1:0]    o_rd_data,
    // Global control from the monitor unit
    input  wire                  i_global_enable,
    // Channel events
    input  wire                  i_act,
    input  wire                  i_pre,
    input  wire                  i_cas_rd,
    input  wire                  i_cas_wr,
    input  wire                  i_refresh,
    input  wire                  i_pre_all,
    input  wire                  i_read_major_mode,
    input  wire                  i_write_major_mode,
    input  wire                  i_rpq_alloc,
    input  wire                  i_rpq_not_empty,
    input  wire                  i_wpq_alloc,
    input  wire                  i_wpq_not_empty,
    input  wire                  i_wpq_full,
    input  wire [7:0]            i_rd_cas_rank,
    input  wire [7:0]            i_wr_cas_rank,
    input  wire                  i_wmm_to_rmm,
    input  wire                  i_wrong_mm,
    input  wire [`INC_W-1:0]     i_buffer_write_occupancy,
    // Overflow message to the global monitor unit
    output wire                  o_overflow_interrupt,
    output wire [`STATUS_W-1:0]  o_overflow_source
);

    integer k;

    // Fixed counter control.
    reg                          fixed_en_reg;
    reg                          fixed_overflow_notify_enable_reg;

    // General counter controls.
    reg  [7:0]                   code_reg  [0:`NUM_GEN-1];
    reg  [7:0]                   umask_reg [0:`NUM_GEN-1];
    reg                          gen_en_reg    [0:`NUM_GEN-1];
    reg                          gen_overflow_notify_enable_reg [0:`NUM_GEN-1];

    // Overflow status and outgoing message.
    reg  [`STATUS_W-1:0]         status_reg;
    reg  [`STATUS_W-1:0]         status_next;
    reg                          msg_reg;
    reg  [`STATUS_W-1:0]         source_reg;

    // Read data.
    reg  [`DATA_W-1:0]           rd_data_reg;
    reg  [`DATA_W-1:0]           rd_data_next;

    // Decoded writes.
    wire                         wr_fixed_ctl;
    wire                         wr_status;
    wire                         fixed_clear;
    wire                         fixed_load_lo;
    wire                         fixed_load_hi;
    wire [`NUM_GEN-1:0]          wr_gen_ctl;
    wire [`NUM_GEN-1:0]          gen_clear;
    wire [`NUM_GEN-1:0]          gen_load_lo;
    wire [`NUM_GEN-1:0]          gen_load_hi;

    // Counter state.
    wire [`COUNT_W-1:0]          fixed_count;
    wire                         fixed_carry;
    wire                         fixed_run;
    wire [`COUNT_W-1:0]          gen_count [0:`NUM_GEN-1];
    wire [`NUM_GEN-1:0]          gen_carry;
    wire [`NUM_GEN-1:0]          gen_overflow_notify_enable_vec;
    wire [`STATUS_W-1:0]         notify;

    assign wr_fixed_ctl  = i_wr_stb & (i_addr == `OFF_FIXED_CTL);
    assign wr_status     = i_wr_stb & (i_addr == `OFF_STATUS);
    // The clear bit is a command and never stored, so it always reads zero.
    assign fixed_clear   = wr_fixed_ctl & i_wr_data[`FLD_FIXED_RST];
    assign fixed_load_lo = i_wr_stb & (i_addr == `OFF_FIXED_LO);
    assign fixed_load_hi = i_wr_stb & (i_addr == `OFF_FIXED_HI);

    // Counting stops when the enable bit is clear or the global unit freezes the set.
    assign fixed_run = fixed_en_reg & i_global_enable;

    // The block clock is the DRAM clock, so one tick is one DRAM cycle.
    count48 fixed_counter (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_count_en (fixed_run),
        .i_inc      (6'h01),
        .i_clear    (fixed_clear),
        .i_load_lo  (fixed_load_lo),
        .i_load_hi  (fixed_load_hi),
        .i_wdata    (i_wr_data),
        .o_count    (fixed_count),
        .o_carry    (fixed_carry)
    );

    genvar g;
    generate
        for (g = 0; g < `NUM_GEN; g = g + 1) begin : gen_ctr
            wire [`INC_W-1:0] inc;
            wire [`ADDR_W-1:0] ctl_off;
            wire [`ADDR_W-1:0] lo_off;

            // Offsets are worked out wide and then cut to the bus width.
            localparam [31:0] CTL_OFF_W = 32'h00000010 + g * 4;
            localparam [31:0] LO_OFF_W  = 32'h00000028 + g * 8;
            assign ctl_off = CTL_OFF_W[`ADDR_W-1:0];
            assign lo_off  = LO_OFF_W[`ADDR_W-1:0];
            assign wr_gen_ctl[g]  = i_wr_stb & (i_addr == ctl_off);
            assign gen_clear[g]   = wr_gen_ctl[g]
                                  & i_wr_data[`FLD_GEN_RST];
            assign gen_load_lo[g] = i_wr_stb & (i_addr == lo_off);
            assign gen_load_hi[g] = i_wr_stb
                                  & (i_addr == lo_off + 8'h04);
            assign gen_overflow_notify_enable_vec[g] = gen_overflow_notify_enable_reg[g];

            event_select selector (
                .i_code                   (code_reg[g]),
                .i_umask                  (umask_reg[g]),
                .i_act                    (i_act),
                .i_pre                    (i_pre),
                .i_cas_rd                 (i_cas_rd),
                .i_cas_wr                 (i_cas_wr),
                .i_refresh                (i_refresh),
                .i_pre_all                (i_pre_all),
                .i_read_major_mode        (i_read_major_mode),
                .i_write_major_mode       (i_write_major_mode),
                .i_rpq_alloc              (i_rpq_alloc),
                .i_rpq_not_empty          (i_rpq_not_empty),
                .i_wpq_alloc              (i_wpq_alloc),
                .i_wpq_not_empty          (i_wpq_not_empty),
                .i_wpq_full               (i_wpq_full),
                .i_rd_cas_rank            (i_rd_cas_rank),
                .i_wr_cas_rank            (i_wr_cas_rank),
                .i_wmm_to_rmm             (i_wmm_to_rmm),
                .i_wrong_mm               (i_wrong_mm),
                .i_buffer_write_occupancy (i_buffer_write_occupancy),
                .o_inc                    (inc)
            );

            count48 counter (
                .i_clk      (i_clk),
                .i_sys_rst  (i_sys_rst),
                .i_count_en (gen_en_reg[g] & i_global_enable),
                .i_inc      (inc),
                .i_clear    (gen_clear[g]),
                .i_load_lo  (gen_load_lo[g]),
                .i_load_hi  (gen_load_hi[g]),
                .i_wdata    (i_wr_data),
                .o_count    (gen_count[g]),
                .o_carry    (gen_carry[g])
            );
        end
    endgenerate

    // Bit 0 of status belongs to the fixed counter, bit n+1 to counter n.
    assign notify = {gen_carry & gen_overflow_notify_enable_vec,
                     fixed_carry & fixed_overflow_notify_enable_reg};

    // A new overflow wins over a same-cycle write-one-to-clear.
    always @* begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~i_wr_data[`STATUS_W-1:0];
        end
        status_next = status_next | notify;
    end

    // Control registers. Reserved bits are not stored and read as zero,
    // which keeps stray writes to them harmless.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            fixed_en_reg    <= 1'b0;
            fixed_overflow_notify_enable_reg <= 1'b0;
            for (k = 0; k < `NUM_GEN; k = k + 1) begin
                code_reg[k]      <= 8'h00;
                umask_reg[k]     <= 8'h00;
                gen_en_reg[k]    <= 1'b0;
                gen_overflow_notify_enable_reg[k] <= 1'b0;
            end
        end else begin
            if (wr_fixed_ctl) begin
                fixed_en_reg    <= i_wr_data[`FLD_EN];
                fixed_overflow_notify_enable_reg <= i_wr_data[`FLD_OVERFLOW_NOTIFY_ENABLE];
            end
            for (k = 0; k < `NUM_GEN; k = k + 1) begin
                if (wr_gen_ctl[k]) begin
                    code_reg[k] <=
                        i_wr_data[`FLD_CODE_HI:`FLD_CODE_LO];
                    umask_reg[k] <=
                        i_wr_data[`FLD_UMASK_HI:`FLD_UMASK_LO];
                    gen_en_reg[k]    <= i_wr_data[`FLD_EN];
                    gen_overflow_notify_enable_reg[k] <= i_wr_data[`FLD_OVERFLOW_NOTIFY_ENABLE];
                end
            end
        end
    end

    // Status and the one-cycle overflow message.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            status_reg <= `STATUS_RESET;
            msg_reg    <= 1'b0;
            source_reg <= `STATUS_RESET;
        end else begin
            status_reg <= status_next;
            msg_reg    <= |notify;
            source_reg <= notify;
        end
    end

    // Read mux. The low and high words are separate reads, so a carry
    // between them can tear a value; software rereads the high word.
    always @* begin
        rd_data_next = {`DATA_W{1'b0}};
        case (i_addr)
            `OFF_FIXED_CTL: begin
                rd_data_next[`FLD_EN]    = fixed_en_reg;
                rd_data_next[`FLD_OVERFLOW_NOTIFY_ENABLE] = fixed_overflow_notify_enable_reg;
            end
            `OFF_STATUS: begin
                rd_data_next[`STATUS_W-1:0] = status_reg;
            end
            `OFF_GEN_CTL0, `OFF_GEN_CTL1, `OFF_GEN_CTL2, `OFF_GEN_CTL3: begin
                rd_data_next[`FLD_CODE_HI:`FLD_CODE_LO] =
                    code_reg[i_addr[3:2]];
                rd_data_next[`FLD_UMASK_HI:`FLD_UMASK_LO] =
                    umask_reg[i_addr[3:2]];
                rd_data_next[`FLD_EN]    = gen_en_reg[i_addr[3:2]];
                rd_data_next[`FLD_OVERFLOW_NOTIFY_ENABLE] = gen_overflow_notify_enable_reg[i_addr[3:2]];
            end
            `OFF_FIXED_LO: begin
                rd_data_next = fixed_count[`DATA_W-1:0];
            end
            `OFF_FIXED_HI: begin
                rd_data_next[`HI_W-1:0] =
                    fixed_count[`COUNT_MSB:`DATA_W];
            end
            `OFF_GEN_LO0: begin
                rd_data_next = gen_count[0][`DATA_W-1:0];
            end
            `OFF_GEN_HI0: begin
                rd_data_next[`HI_W-1:0] = gen_count[0][`COUNT_MSB:`DATA_W];
            end
            `OFF_GEN_LO1: begin
                rd_data_next = gen_count[1][`DATA_W-1:0];
            end
            `OFF_GEN_HI1: begin
                rd_data_next[`HI_W-1:0] = gen_count[1][`COUNT_MSB:`DATA_W];
            end
            `OFF_GEN_LO2: begin
                rd_data_next = gen_count[2][`DATA_W-1:0];
            end
            `OFF_GEN_HI2: begin
                rd_data_next[`HI_W-1:0] = gen_count[2][`COUNT_MSB:`DATA_W];
            end
            `OFF_GEN_LO3: begin
                rd_data_next = gen_count[3][`DATA_W-1:0];
            end
            `OFF_GEN_HI3: begin
                rd_data_next[`HI_W-1:0] = gen_count[3][`COUNT_MSB:`DATA_W];
            end
            default: begin
                rd_data_next = {`DATA_W{1'b0}};
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_data_reg <= {`DATA_W{1'b0}};
        end else if (i_rd_stb) begin
            rd_data_reg <= rd_data_next;
        end else begin
            rd_data_reg <= {`DATA_W{1'b0}};
        end
    end

    assign o_rd_data            = rd_data_reg;
    assign o_overflow_interrupt = msg_reg;
    assign o_overflow_source    = source_reg;

endmodule
`default_nettype wire

//--- inc/perf_counters_defs.vh
// Offsets, field positions, event codes and widths of the channel counters.
`ifndef PERF_COUNTERS_DEFS_VH
`define PERF_COUNTERS_DEFS_VH

// Register bus shape.
`define ADDR_W          8
`define DATA_W          32

// Counter shape.
`define COUNT_W         48
`define COUNT_MSB       47
`define HI_W            16
`define INC_W           6
`define NUM_GEN         4

// Byte offsets of the 32-bit registers.
`define OFF_FIXED_CTL   8'h00
`define OFF_STATUS      8'h04
`define OFF_GEN_CTL0    8'h10
`define OFF_GEN_CTL1    8'h14
`define OFF_GEN_CTL2    8'h18
`define OFF_GEN_CTL3    8'h1c
`define OFF_FIXED_LO    8'h20
`define OFF_FIXED_HI    8'h24
`define OFF_GEN_LO0     8'h28
`define OFF_GEN_HI0     8'h2c
`define OFF_GEN_LO1     8'h30
`define OFF_GEN_HI1     8'h34
`define OFF_GEN_LO2     8'h38
`define OFF_GEN_HI2     8'h3c
`define OFF_GEN_LO3     8'h40
`define OFF_GEN_HI3     8'h44

// Control fields.
`define FLD_EN          22
`define FLD_OVERFLOW_NOTIFY_ENABLE       20
`define FLD_FIXED_RST   19
`define FLD_GEN_RST     17
`define FLD_UMASK_HI    15
`define FLD_UMASK_LO    8
`define FLD_CODE_HI     7
`define FLD_CODE_LO     0
`define STATUS_W        5
`define STATUS_FIXED    0

// Reset values.
`define CTL_RESET       32'h00000000
`define COUNT_RESET     48'h000000000000
`define STATUS_RESET    5'h00

// Event codes.
`define EV_CLOCKTICKS   8'h00
`define EV_ACTIVATE     8'h01
`define EV_PRECHARGE    8'h02
`define EV_COLUMN       8'h04
`define EV_REFRESH      8'h05
`define EV_PRE_ALL      8'h06
`define EV_MAJOR_MODE   8'h07
`define EV_RPQ_ALLOC    8'h10
`define EV_RPQ_NE       8'h11
`define EV_WPQ_ALLOC    8'h20
`define EV_WPQ_NE       8'h21
`define EV_WPQ_FULL     8'h22
`define EV_BUF_OCC      8'h91
`define EV_WMM_TO_RMM   8'hc0
`define EV_WRONG_MM     8'hc1
`define EV_RD_RANK_GRP  5'h16
`define EV_WR_RANK_GRP  5'h17

`endif

//--- src/count48.v
// One 48-bit event counter with preload, clear and carry-out detection.
`default_nettype none
`include "perf_counters_defs.vh"

module count48 (
    // Clock and reset
    input  wire                  i_clk,
    input  wire                  i_sys_rst,
    // Control
    input  wire                  i_count_en,
    input  wire [`INC_W-1:0]     i_inc,
    input  wire                  i_clear,
    input  wire                  i_load_lo,
    input  wire                  i_load_hi,
    input  wire [`DATA_W-1:0]    i_wdata,
    // State
    output wire [`COUNT_W-1:0]   o_count,
    output wire                  o_carry
);

    reg  [`COUNT_W-1:0] count_reg;
    reg  [`COUNT_W-1:0] count_next;
    wire [`COUNT_W:0]   sum;

    // The wide sum keeps the carry out of the top bit visible.
    assign sum = {1'b0, count_reg} + {{(`COUNT_W+1-`INC_W){1'b0}}, i_inc};
    assign o_carry = i_count_en & ~i_clear & ~i_load_lo & ~i_load_hi
                   & sum[`COUNT_W];
    assign o_count = count_reg;

    // Clear beats preload, and preload beats counting.
    always @* begin
        count_next = count_reg;
        if (i_clear) begin
            count_next = `COUNT_RESET;
        end else if (i_load_lo) begin
            count_next = {count_reg[`COUNT_MSB:`DATA_W], i_wdata};
        end else if (i_load_hi) begin
            count_next = {i_wdata[`HI_W-1:0], count_reg[`DATA_W-1:0]};
        end else if (i_count_en) begin
            count_next = sum[`COUNT_MSB:0];
        end
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_reg <= `COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule
`default_nettype wire

//--- src/event_select.v
// Maps an event code and sub-event mask onto a per-cycle increment.
`default_nettype none
`include "perf_counters_defs.vh"

module event_select (
    // Selection
    input  wire [7:0]            i_code,
    input  wire [7:0]            i_umask,
    // Channel events
    input  wire                  i_act,
    input  wire                  i_pre,
    input  wire                  i_cas_rd,
    input  wire                  i_cas_wr,
    input  wire                  i_refresh,
    input  wire                  i_pre_all,
    input  wire                  i_read_major_mode,
    input  wire                  i_write_major_mode,
    input  wire                  i_rpq_alloc,
    input  wire                  i_rpq_not_empty,
    input  wire                  i_wpq_alloc,
    input  wire                  i_wpq_not_empty,
    input  wire                  i_wpq_full,
    input  wire [7:0]            i_rd_cas_rank,
    input  wire [7:0]            i_wr_cas_rank,
    input  wire                  i_wmm_to_rmm,
    input  wire                  i_wrong_mm,
    input  wire [`INC_W-1:0]     i_buffer_write_occupancy,
    // Result
    output reg  [`INC_W-1:0]     o_inc
);

    wire cas_hit;
    wire mode_hit;

    // For column commands mask bits 1:0 pick reads and bits 3:2 writes; for major mode bit 0 picks reads, bit 1 writes.
    assign cas_hit = (i_cas_rd & |i_umask[1:0]) | (i_cas_wr & |i_umask[3:2]);
    assign mode_hit = (i_read_major_mode & i_umask[0])
                    | (i_write_major_mode & i_umask[1]);

    always @* begin
        o_inc = {`INC_W{1'b0}};
        case (i_code)
            `EV_CLOCKTICKS: o_inc = 6'h01;
            `EV_ACTIVATE:   o_inc = {5'h00, i_act};
            `EV_PRECHARGE:  o_inc = {5'h00, i_pre};
            `EV_COLUMN:     o_inc = {5'h00, cas_hit};
            `EV_REFRESH:    o_inc = {5'h00, i_refresh};
            `EV_PRE_ALL:    o_inc = {5'h00, i_pre_all};
            `EV_MAJOR_MODE: o_inc = {5'h00, mode_hit};
            `EV_RPQ_ALLOC:  o_inc = {5'h00, i_rpq_alloc};
            `EV_RPQ_NE:     o_inc = {5'h00, i_rpq_not_empty};
            `EV_WPQ_ALLOC:  o_inc = {5'h00, i_wpq_alloc};
            `EV_WPQ_NE:     o_inc = {5'h00, i_wpq_not_empty};
            `EV_WPQ_FULL:   o_inc = {5'h00, i_wpq_full};
            `EV_BUF_OCC:    o_inc = i_buffer_write_occupancy;
            `EV_WMM_TO_RMM: o_inc = {5'h00, i_wmm_to_rmm};
            `EV_WRONG_MM:   o_inc = {5'h00, i_wrong_mm};
            default: begin
                if (i_code[7:3] == `EV_RD_RANK_GRP) begin
                    o_inc = {5'h00, i_rd_cas_rank[i_code[2:0]]};
                end else if (i_code[7:3] == `EV_WR_RANK_GRP) begin
                    o_inc = {5'h00, i_wr_cas_rank[i_code[2:0]]};
                end else begin
                    o_inc = {`INC_W{1'b0}};
                end
            end
        endcase
    end

endmodule
`default_nettype wire

//--- tb/perf_counters_props.sv
// Checker for the counter set's register port and overflow message.
`default_nettype none
module perf_counters_chk (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // Register port and global enable
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic        i_wr_stb,
    input wire logic        i_rd_stb,
    input wire logic        i_global_enable,
    // Outputs watched
    input wire logic [31:0] o_rd_data,
    input wire logic        o_overflow_interrupt,
    input wire logic [4:0]  o_overflow_source
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    chk_msg_source: assert property (
        o_overflow_interrupt == (o_overflow_source != 5'h00))
        else $error("overflow source and message disagree");
    chk_rd_idle: assert property (
        !$past(i_rd_stb) |-> o_rd_data == 32'h0)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property (
        i_rd_stb && i_addr == 8'hfc |=> o_rd_data == 32'h0)
        else $error("unmapped read not zero");
    chk_ctl_reads: assert property (
        i_rd_stb && i_addr == 8'h00 |=> o_rd_data[19:0] == 20'h0
        && !o_rd_data[21] && o_rd_data[31:23] == 9'h0)
        else $error("fixed control reads unstored bits");
    chk_hi_upper: assert property (
        i_rd_stb && i_addr[2] && i_addr >= 8'h24 && i_addr <= 8'h44
        |=> o_rd_data[31:16] == 16'h0)
        else $error("upper count word not zero");
    chk_msg_global: assert property (
        o_overflow_interrupt |-> $past(i_global_enable))
        else $error("overflow while globally stopped");
    chk_fixed_clear: assert property (
        i_wr_stb && i_addr == 8'h00 && i_wr_data[19]
        ##1 i_rd_stb && i_addr == 8'h20 |=> o_rd_data == 32'h0)
        else $error("fixed counter not cleared");
    chk_lo_load: assert property (
        i_wr_stb && i_addr == 8'h28 ##1 i_rd_stb && i_addr == 8'h28
        |=> o_rd_data == $past(i_wr_data, 2))
        else $error("preload not read back");
    cover property (o_overflow_interrupt && o_overflow_source[0]);
    cover property (o_overflow_interrupt && o_overflow_source[3]);
    cover property (i_rd_stb ##1 i_rd_stb);
endmodule
bind memory_channel_perf_counters perf_counters_chk u_chk (
    .i_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
    .i_global_enable, .o_rd_data, .o_overflow_interrupt,
    .o_overflow_source
);
`default_nettype wire

//--- tb/global_monitor_model.sv
// Global monitor model: collects overflow messages and freezes counting.
`default_nettype none
module global_monitor_model (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_resume,
    input  wire logic       i_msg,
    input  wire logic [4:0] i_source,
    output var  logic       o_enable,
    output var  logic [4:0] o_seen,
    output var  logic [7:0] o_msgs
);
    timeunit 1ns;
    timeprecision 1ns;
    // Freezing one edge late lets the wrapped count be seen moving on.
    always @(posedge i_clk) begin
        if (i_sys_rst || i_resume) begin
            o_enable <= 1'b1;
            o_seen   <= 5'h00;
            o_msgs   <= 8'h00;
        end else if (i_msg) begin
            o_enable <= 1'b0;
            o_seen   <= o_seen | i_source;
            o_msgs   <= o_msgs + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/memory_channel_perf_counters_tb_top.sv
// Self-checking bench for the channel counter set.
`default_nettype none
module memory_channel_perf_counters_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wstb = 1'b0;
    logic        rstb = 1'b0;
    logic        resume = 1'b0;
    logic [30:0] ev = 31'h0;
    logic [5:0]  occ = 6'h00;
    logic [31:0] rd_data;
    logic        glob_en;
    logic        msg;
    logic [4:0]  src;
    logic [4:0]  seen;
    logic [7:0]  msgs;
    logic [15:0] t;
    int          err_total = 0;
    int          checks_done = 0;
    logic [15:0] tbl [15] = '{16'h0001, 16'h0002, 16'h0104, 16'h0404,
        16'h0005, 16'h0006, 16'h0107, 16'h0207, 16'h0010, 16'h0011,
        16'h0020, 16'h0021, 16'h0022, 16'h00c0, 16'h00c1};
    memory_channel_perf_counters dut (
        .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_stb(wstb), .i_rd_stb(rstb), .o_rd_data(rd_data),
        .i_global_enable(glob_en), .i_act(ev[0]), .i_pre(ev[1]),
        .i_cas_rd(ev[2]), .i_cas_wr(ev[3]), .i_refresh(ev[4]),
        .i_pre_all(ev[5]), .i_read_major_mode(ev[6]),
        .i_write_major_mode(ev[7]), .i_rpq_alloc(ev[8]),
        .i_rpq_not_empty(ev[9]), .i_wpq_alloc(ev[10]),
        .i_wpq_not_empty(ev[11]), .i_wpq_full(ev[12]),
        .i_wmm_to_rmm(ev[13]), .i_wrong_mm(ev[14]),
        .i_rd_cas_rank(ev[22:15]), .i_wr_cas_rank(ev[30:23]),
        .i_buffer_write_occupancy(occ), .o_overflow_interrupt(msg),
        .o_overflow_source(src));
    global_monitor_model partner (
        .i_clk(clk), .i_sys_rst(rst), .i_resume(resume), .i_msg(msg),
        .i_source(src), .o_enable(glob_en), .o_seen(seen), .o_msgs(msgs));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic give_verdict;
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr  <= a;
        wdata <= v;
        wstb  <= 1'b1;
        @(posedge clk);
        wstb  <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask
    // A lost message must not hang the run.
    task automatic wait_msg;
        int n;
        n = 0;
        while (msgs === 8'h00 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (msgs === 8'h00) begin
            check(32'h1, 32'h0);
            give_verdict;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        rd(8'h00, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h28, 32'hdeadbeef);
        rd(8'h28, 32'hdeadbeef);
        wr(8'h2c, 32'hffff1234);
        rd(8'h2c, 32'h00001234);
        rd(8'hfc, 32'h0);
        wr(8'h00, 32'h00480000);
        rd(8'h20, 32'h0);
        rd(8'h20, 32'h1);
        rd(8'h00, 32'h00400000);
        wr(8'h00, 32'h0);
        wr(8'h20, 32'h55);
        rd(8'h20, 32'h55);
        rd(8'h20, 32'h55);
        wr(8'h24, 32'h0000ffff);
        wr(8'h20, 32'hfffffffd);
        wr(8'h00, 32'h00500000);
        wait_msg;
        check({27'h0, seen}, 32'h1);
        rd(8'h20, 32'h1);
        rd(8'h24, 32'h0);
        rd(8'h04, 32'h1);
        wr(8'h04, 32'h1);
        rd(8'h04, 32'h0);
        resume <= 1'b1;
        @(posedge clk);
        resume <= 1'b0;
        #1;
        for (int i = 0; i < 31; i++) begin
            t = (i < 15) ? tbl[i] : 16'h00a1 + 16'(i);
            wr(8'h10, {16'h0042, t});
            ev <= 31'h1 << i;
            repeat (3) @(posedge clk);
            ev <= 31'h0;
            #1;
            rd(8'h28, 32'h3);
            rd(8'h10, {16'h0040, t});
        end
        wr(8'h10, 32'h00420091);
        occ <= 6'h20;
        repeat (2) @(posedge clk);
        occ <= 6'h00;
        #1;
        rd(8'h28, 32'h40);
        wr(8'h3c, 32'h0000ffff);
        wr(8'h38, 32'hfffffff0);
        wr(8'h18, 32'h00500091);
        occ <= 6'h20;
        @(posedge clk);
        occ <= 6'h00;
        #1;
        wait_msg;
        check({27'h0, seen}, 32'h8);
        rd(8'h38, 32'h10);
        give_verdict;
    end
endmodule
`default_nettype wire
